// >>> bench/mau_host_model.sv
// Host model issuing register, block and memory accesses
`timescale 1ns/1ps
`default_nettype none
module mau_host_model (
  input wire logic clk_i, // Clock
  input wire logic [7:0] io_rdata_i, // Register read data
  input wire logic [7:0] mem_rdata_i, // Memory read data
  output logic [15:0] io_addr_o, // Address
  output logic [7:0] io_wdata_o, // Write data
  output logic io_wr_o, // Write strobe
  output logic io_rd_o, // Read strobe
  output logic mem_sel_o, // Memory select
  output logic [8:0] mem_addr_o, // Memory address
  output logic [7:0] mem_wdata_o, // Memory data
  output logic mem_wr_o, // Memory write
  output logic mem_rd_o // Memory read
);
  logic [7:0] buf_q [0:15]; // Block transfer bytes
  logic [7:0] q; // Last register byte
  logic [7:0] mq; // Last memory byte
  initial begin
    {io_addr_o, io_wdata_o, io_wr_o, io_rd_o} = 26'h0;
    {mem_sel_o, mem_addr_o, mem_wdata_o, mem_wr_o, mem_rd_o} = 20'h0;
  end
  // Released address and data go inverted and strobes go low, so stale values never pass for good ones
  task io(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_i);
    {io_addr_o, io_wdata_o, io_wr_o, io_rd_o} <= {a, d, w, !w};
    @(negedge clk_i);
    q = io_rdata_i;
    {io_addr_o, io_wdata_o, io_wr_o, io_rd_o} <= {~a, ~d, 2'b00};
  endtask
  // Count runs down in the high byte, register up in the low byte
  task blk(input logic w, input logic [7:0] base, input logic [7:0] n);
    for (int i = 0; i < n; i++) begin
      io(w, {n - 8'(i), base + 8'(i)}, buf_q[i]);
      if (!w) buf_q[i] = q;
    end
  endtask
  task mem(input logic w, input logic s, input logic [8:0] a,
    input logic [7:0] d);
    @(negedge clk_i);
    {mem_sel_o, mem_addr_o, mem_wdata_o, mem_wr_o, mem_rd_o} <= {s, a, d, w, !w};
    @(negedge clk_i);
    mq = mem_rdata_i;
    {mem_sel_o, mem_addr_o, mem_wdata_o, mem_wr_o, mem_rd_o} <= {~s, ~a, ~d, 2'b00};
  endtask
endmodule // mau_host_model
`default_nettype wire

// >>> bench/mau_top_props.sv
// Checker of bank start, status and read port behaviour
`timescale 1ns/1ps
`default_nettype none
module mau_top_props (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic [15:0] io_addr_i, // Address
  input wire logic [7:0] io_wdata_i, // Write data
  input wire logic io_wr_i, // Write strobe
  input wire logic io_rd_i, // Read strobe
  input wire logic [7:0] io_rdata_o, // Read data
  input wire logic mem_sel_i, // Memory select
  input wire logic [8:0] mem_addr_i, // Memory address
  input wire logic [7:0] mem_wdata_i, // Memory data
  input wire logic mem_wr_i, // Memory write
  input wire logic mem_rd_i, // Memory read
  input wire logic [7:0] mem_rdata_o, // Memory read data
  input wire logic compute_bank_busy_o // Busy
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Host requests that matter to the bank states
  sequence s_top_wr;
    io_wr_i && io_addr_i[7:0] == 8'h0c;
  endsequence
  sequence s_ctl_last;
    io_wr_i && io_addr_i == 16'h0107;
  endsequence
  sequence s_stat_rd;
    io_rd_i && io_addr_i[7:0] == 8'h0d;
  endsequence
  AST_RST_IDLE: assert property ($fell(rst_i) |-> !compute_bank_busy_o)
    else $error("busy right after reset");
  AST_TOP_START: assert property (s_top_wr ##0 !compute_bank_busy_o |=> compute_bank_busy_o)
    else $error("top byte write did not start");
  AST_CTL_START: assert property (s_ctl_last ##0 !compute_bank_busy_o |=> compute_bank_busy_o)
    else $error("final control write did not start");
  AST_QUEUED: assert property (s_top_wr ##0 compute_bank_busy_o |=> compute_bank_busy_o)
    else $error("queued start lost busy");
  // A plain write below the accumulator must not start anything
  AST_NO_START: assert property (io_wr_i && io_addr_i[7:0] < 8'h08 &&
    io_addr_i[15:8] != 8'h01 && !compute_bank_busy_o |=> !compute_bank_busy_o)
    else $error("plain write started a calculation");
  AST_STAT_CODE: assert property (s_stat_rd |=>
    io_rdata_o[7:4] == 4'h0 && io_rdata_o[1:0] != 2'b10)
    else $error("bad host bank code");
  AST_STAT_BUSY: assert property (s_stat_rd |=> io_rdata_o[3:2] != 2'b01 &&
    (io_rdata_o[3:2] == 2'b10) == $past(compute_bank_busy_o))
    else $error("compute code disagrees with busy");
  AST_UNMAPPED: assert property (io_rd_i && io_addr_i[7:0] > 8'h0d
    |=> io_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  AST_IO_HOLD: assert property (!io_rd_i |=> $stable(io_rdata_o))
    else $error("read data moved without a read");
  AST_MEM_HOLD: assert property (!mem_rd_i |=> $stable(mem_rdata_o))
    else $error("memory data moved without a read");
endmodule // mau_top_props
bind mau_top mau_top_props u_props (.*);
`default_nettype wire

// >>> bench/mau_top_tb.sv
// Self-checking bench of the dual-bank multiply-accumulate unit
`timescale 1ns/1ps
`default_nettype none
module mau_top_tb;
  logic clk_i = 1'b0, rst_i = 1'b1, io_wr_i, io_rd_i, mem_sel_i;
  logic mem_wr_i, mem_rd_i, compute_bank_busy_o;
  logic [15:0] io_addr_i;
  logic [8:0] mem_addr_i;
  logic [7:0] io_wdata_i, io_rdata_o, mem_wdata_i, mem_rdata_o, st;
  logic [15:0] bcnt = 16'h0; // Busy cycles of one calculation
  int fails = 0, cmp_count = 0, cyc = 0;
  // Rows: {x0, y0, x1, y1}, signed flag, length
  logic [72:0] rows [4] = '{{64'hffff_ffff_0000_0000, 1'b0, 8'h00},
    {64'hffff_ffff_0001_0001, 1'b1, 8'h01},
    {64'hffff_0010_0003_0004, 1'b1, 8'h02},
    {64'hffff_ffff_ffff_ffff, 1'b0, 8'hff}};
  mau_top DUT (.*);
  mau_host_model host (.clk_i(clk_i), .io_rdata_i(io_rdata_o),
    .mem_rdata_i(mem_rdata_o), .io_addr_o(io_addr_i), .io_wdata_o(io_wdata_i),
    .io_wr_o(io_wr_i), .io_rd_o(io_rd_i), .mem_sel_o(mem_sel_i),
    .mem_addr_o(mem_addr_i), .mem_wdata_o(mem_wdata_i),
    .mem_wr_o(mem_wr_i), .mem_rd_o(mem_rd_i));
  initial forever #20 clk_i = ~clk_i;
  // Cycle ceiling cuts a hang short; busy is counted edge by edge
  always @(posedge clk_i) begin
    cyc++;
    if (compute_bank_busy_o === 1'b1) bcnt <= bcnt + 16'h1;
    if (cyc == 20000) begin
      fails++;
      print_verdict;
    end
  end
  // Sum of products alternating words 0 and 1, length + 1 steps
  function automatic logic [39:0] mac(input logic [63:0] w, input logic s,
    input logic [7:0] n);
    logic [39:0] acc, a, b;
    logic [31:0] xy;
    acc = 40'h0;
    for (int i = 0; i <= n; i++) begin
      xy = i[0] ? w[31:0] : w[63:32];
      a = s ? {{24{xy[31]}}, xy[31:16]} : {24'h0, xy[31:16]};
      b = s ? {{24{xy[15]}}, xy[15:0]} : {24'h0, xy[15:0]};
      acc = acc + a * b;
    end
    return acc;
  endfunction
  task chk(input string n, input logic [39:0] e, input logic [39:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("wrong value %0s exp %h got %h", n, e, g);
    end
  endtask
  task stat;
    host.io(1'b0, 16'h000d, 8'h00);
    st = host.q;
  endtask
  task wait_done;
    for (int k = 0; k < 300; k++) begin
      stat;
      if (st[1:0] === 2'b11) break;
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic run(input logic [72:0] r);
    logic [15:0] v;
    logic [7:0] cfg [8] = '{8'h0, 8'h1, 8'h0, 8'h0, 8'h1, 8'h0, r[7:0],
      {7'h0, r[8]}};
    // Words 0 and 1 of x and y, high byte at the odd address
    for (int m = 0; m < 4; m++) begin
      v = r[72 - 16 * m -: 16];
      host.mem(1'b1, m[0], {7'h0, m[1], 1'b1}, v[15:8]);
      host.mem(1'b1, m[0], {7'h0, m[1], 1'b0}, v[7:0]);
    end
    host.mem(1'b0, 1'b0, 9'h001, 8'h00);
    chk("mem byte", r[72:65], host.mq);
    for (int k = 0; k < 8; k++) host.buf_q[k] = cfg[k];
    bcnt = 16'h0;
    host.blk(1'b1, 8'h00, 8'h08);
    wait_done;
    chk("busy cycles", r[7:0] + 1, bcnt);
    chk("status done", 8'h03, st);
    host.blk(1'b0, 8'h08, 8'h04);
    host.io(1'b0, 16'h000c, 8'h00);
    chk("result", mac(r[72:9], r[8], r[7:0]), {host.q, host.buf_q[3],
      host.buf_q[2], host.buf_q[1], host.buf_q[0]});
    stat;
    chk("status empty", 8'h00, st);
  endtask
  initial begin
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
    foreach (rows[i]) run(rows[i]);
    $display("test rows done");
    // A second start while busy waits, then swaps at the end
    // Stale readout bytes would aim the pointers at unwritten words
    for (int k = 0; k < 6; k++) host.buf_q[k] = (k % 3 == 1) ? 8'h01 : 8'h00;
    host.buf_q[6] = 8'd20;
    host.buf_q[7] = 8'h00;
    host.blk(1'b1, 8'h00, 8'h08);
    host.io(1'b1, 16'h000c, 8'h00);
    stat;
    chk("queued", 8'h09, st);
    wait_done;
    chk("swapped", 8'h0b, st);
    host.io(1'b0, 16'h000c, 8'h00);
    chk("top byte", mac({4{16'hffff}}, 1'b0, 8'd20) >> 32, host.q);
    stat;
    // Queued bank kept reset settings, one step, so it swaps in at once
    chk("top read empties", 8'h03, st);
    wait_done;
    host.io(1'b1, 16'h0000, 8'h00);
    stat;
    chk("write empties", 8'h00, st);
    $display("test overlap done");
    // Plain writes, status write and unmapped read change nothing
    host.io(1'b1, 16'h0207, 8'h00);
    host.io(1'b1, 16'h010d, 8'hff);
    host.io(1'b0, 16'h000e, 8'h00);
    chk("unmapped", 8'h00, host.q);
    stat;
    chk("no start", 8'h00, st);
    host.io(1'b1, 16'h0206, 8'h40);
    host.io(1'b1, 16'h0108, 8'h00);
    stat;
    chk("low byte start", 8'h08, st);
    // Reset in mid-calculation
    @(negedge clk_i) rst_i = 1'b1;
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
    chk("busy after reset", 40'h0, compute_bank_busy_o);
    stat;
    chk("reset status", 8'h00, st);
    // Idle engine: a plain top-byte write starts a one-step calculation
    host.io(1'b1, 16'h000c, 8'h00);
    stat;
    chk("top byte start", 8'h03, st);
    $display("test reset done");
    print_verdict;
  end
endmodule // mau_top_tb
`default_nettype wire

// >>> core/mau_mac_step.v
// One multiply-and-add step: 16x16 product added to a 40-bit accumulator
`timescale 1ns/1ps
`default_nettype none

module mau_mac_step (
  input wire [15:0] x_i,      // Operand from x memory
  input wire [15:0] y_i,      // Operand from y memory
  input wire signed_i,        // Treat operands as two's complement
  input wire [39:0] acc_i,    // Accumulator before the step
  output wire [39:0] acc_o    // Accumulator after the step
);

  wire signed [31:0] sprod;
  wire [31:0] uprod;
  wire [39:0] ext;

  // Both products are built; the flag only picks one
  assign sprod = $signed(x_i) * $signed(y_i);
  assign uprod = x_i * y_i;
  assign ext = signed_i ? {{8{sprod[31]}}, sprod} : {8'h00, uprod};
  assign acc_o = acc_i + ext;

endmodule // mau_mac_step
`default_nettype wire

// >>> core/mau_op_ram.v
// Operand memory: 256 x 16 words, 16-bit read port and 8-bit host port
`timescale 1ns/1ps
`default_nettype none

module mau_op_ram (
  input wire clk_i,            // System clock
  input wire [7:0] rd_addr_i,  // Word index for the multiplier port
  output wire [15:0] rd_data_o, // Word to the multiplier
  input wire [8:0] cpu_addr_i, // Byte address, bit 0 picks the byte
  input wire cpu_wr_i,         // Host byte write strobe
  input wire [7:0] cpu_wdata_i, // Host write byte
  output wire [7:0] cpu_rdata_o // Host read byte
);

  reg [15:0] mem_q [0:255];
  wire [7:0] cpu_word;
  wire [15:0] cpu_sel;

  // Multiplier port reads without latency so a step fits one cycle
  assign rd_data_o = mem_q[rd_addr_i];
  assign cpu_word = cpu_addr_i[8:1];
  assign cpu_sel = mem_q[cpu_word];
  assign cpu_rdata_o = cpu_addr_i[0] ? cpu_sel[15:8] : cpu_sel[7:0];

  // Host byte writes; contents are not reset
  always @(posedge clk_i) begin
    if (cpu_wr_i) begin
      if (cpu_addr_i[0]) begin
        mem_q[cpu_word][15:8] <= cpu_wdata_i;
      end else begin
        mem_q[cpu_word][7:0] <= cpu_wdata_i;
      end
    end
  end

endmodule // mau_op_ram
`default_nettype wire

// >>> core/mau_top.v
// Dual-bank multiply-accumulate unit with host register and memory ports
//
// Operation
// (RULE_01) Two 40-bit accumulators; 32-bit product added back into one.
// (RULE_02) Each multiply-and-add step with write-back finishes in one cycle.
// (RULE_03) Two operand memories x and y, 256 x 16, 16-bit multiplier port.
// (RULE_04) Each operand memory also has an 8-bit host read/write port.
// (RULE_05) Register select from low address byte; high byte flags last transfer.
// (RULE_06) Host counts high byte down; final transfer carries 01h.
// (RULE_07) Host bank EMPTY to READY on top-byte write or final ctl/acc write.
// (RULE_08) Final-transfer control write also clears the host bank accumulator.
// (RULE_09) READY with compute bank idle or done swaps banks, compute goes busy.
// (RULE_10) READY waits while a calculation runs, then swaps banks.
// (RULE_11) Finished calculation swaps when host bank EMPTY or READY.
// (RULE_12) Host bank DONE to EMPTY on top-byte read or final low-byte read.
// (RULE_13) Any register write except status moves host bank DONE to EMPTY.
// (RULE_14) Host reads one to five result bytes, writes any register subset.
// (RULE_15) Plain accesses drive high byte 01h only to request a change.
// (RULE_16) Each bank owns accumulator, pointers, reloads and length.
// (RULE_17) Host bank status in bits 1:0: 00 EMPTY, 01 READY, 11 DONE.
// (RULE_18) Compute bank status in bits 3:2: 00 EMPTY, 10 BUSY, 11 DONE.
// (RULE_19) After reset both banks EMPTY and nothing running.
`timescale 1ns/1ps
`default_nettype none
`include "mau_defs.vh"

module mau_top (
  input wire clk_i,             // System clock, 25 MHz
  input wire rst_i,             // Asynchronous reset, active high
  input wire [15:0] io_addr_i,  // I/O address, high byte is block count
  input wire [7:0] io_wdata_i,  // I/O write data
  input wire io_wr_i,           // I/O write strobe, one cycle
  input wire io_rd_i,           // I/O read strobe, one cycle
  output wire [7:0] io_rdata_o, // I/O read data, valid after the strobe
  input wire mem_sel_i,         // Operand memory select: 0 x, 1 y
  input wire [8:0] mem_addr_i,  // Operand memory byte address
  input wire [7:0] mem_wdata_i, // Operand memory write byte
  input wire mem_wr_i,          // Operand memory write strobe
  input wire mem_rd_i,          // Operand memory read strobe
  output wire [7:0] mem_rdata_o, // Operand memory read byte
  output wire compute_bank_busy_o       // Calculation in progress
);

  // Per-bank control state and accumulators
  reg [7:0] xs_q [0:1];
  reg [7:0] xe_q [0:1];
  reg [7:0] xr_q [0:1];
  reg [7:0] ys_q [0:1];
  reg [7:0] ye_q [0:1];
  reg [7:0] yr_q [0:1];
  reg [7:0] len_q [0:1];
  reg [7:0] ctl_q [0:1];
  reg [39:0] acc_q [0:1];

  // Bank roles and status
  reg dbank_q;
  reg [1:0] ds_q;
  reg [1:0] cs_q;
  reg [1:0] ds_d;
  reg [1:0] cs_d;
  reg [1:0] ds_mid;
  reg [1:0] cs_mid;
  reg swap;
  reg start;

  // Calculation walk
  reg [7:0] xptr_q;
  reg [7:0] yptr_q;
  reg [7:0] cnt_q;

  // Read data holding registers
  reg [7:0] rdata_q;
  reg [7:0] rd_mux;
  reg [7:0] mrdata_q;

  wire cbank;
  wire [7:0] lo;
  wire last;
  wire sel_ac_low;
  wire sel_ac4;
  wire sel_ctl;
  wire sel_stat;
  wire hit;
  wire wr_any;
  wire ready_ev;
  wire empty_ev;
  wire clr_acc;
  wire step;
  wire [15:0] x_word;
  wire [15:0] y_word;
  wire [39:0] acc_sum;
  wire [39:0] dacc;
  wire [7:0] x_byte;
  wire [7:0] y_byte;
  integer b;

  assign cbank = ~dbank_q;
  assign step = (cs_q == `MAU_CS_BUSY);
  assign compute_bank_busy_o = step;

  // Address decode from the low byte, final transfer from the high byte
  assign lo = io_addr_i[7:0]; // RULE_05
  assign last = (io_addr_i[15:8] == `MAU_LAST_XFER); // RULE_05
  assign sel_ac_low = (lo == `MAU_AC0) || (lo == `MAU_AC1) ||
                      (lo == `MAU_AC2) || (lo == `MAU_AC3);
  assign sel_ac4 = (lo == `MAU_AC4);
  assign sel_ctl = (lo == `MAU_CTL);
  assign sel_stat = (lo == `MAU_STAT);
  assign hit = (lo <= `MAU_STAT);

  // Bank events; the count itself is the host's to maintain
  assign wr_any = io_wr_i && hit && !sel_stat; // RULE_13
  assign ready_ev = io_wr_i &&
                    (sel_ac4 || (last && (sel_ctl || sel_ac_low))); // RULE_07
  assign empty_ev = io_rd_i && (sel_ac4 || (last && sel_ac_low)); // RULE_12
  assign clr_acc = io_wr_i && last && sel_ctl; // RULE_08

  // Operand memories, multiplier side walks the compute bank pointers
  mau_op_ram u_xram (
    .clk_i(clk_i),
    .rd_addr_i(xptr_q),
    .rd_data_o(x_word),
    .cpu_addr_i(mem_addr_i),
    .cpu_wr_i(mem_wr_i && !mem_sel_i),
    .cpu_wdata_i(mem_wdata_i),
    .cpu_rdata_o(x_byte)
  ); // RULE_03 RULE_04

  mau_op_ram u_yram (
    .clk_i(clk_i),
    .rd_addr_i(yptr_q),
    .rd_data_o(y_word),
    .cpu_addr_i(mem_addr_i),
    .cpu_wr_i(mem_wr_i && mem_sel_i),
    .cpu_wdata_i(mem_wdata_i),
    .cpu_rdata_o(y_byte)
  ); // RULE_03 RULE_04

  // Single-cycle step into the compute bank accumulator
  mau_mac_step u_mac (
    .x_i(x_word),
    .y_i(y_word),
    .signed_i(ctl_q[cbank][`MAU_CTL_SIGNED]),
    .acc_i(acc_q[cbank]),
    .acc_o(acc_sum)
  ); // RULE_01 RULE_02

  // Next bank status; read/write effects first, then the swap decision
  always @* begin
    ds_mid = ds_q;
    if ((ds_q == `MAU_DS_DONE) && (wr_any || empty_ev)) begin
      ds_mid = `MAU_DS_EMPTY; // RULE_12 RULE_13
    end
    if (ready_ev && (ds_mid == `MAU_DS_EMPTY)) begin
      ds_mid = `MAU_DS_READY; // RULE_07
    end
    cs_mid = cs_q;
    if (step && (cnt_q == 8'h00)) begin
      cs_mid = `MAU_CS_DONE;
    end
    swap = 1'b0;
    start = 1'b0;
    ds_d = ds_mid;
    cs_d = cs_mid;
    if ((ds_mid == `MAU_DS_READY) && (cs_mid != `MAU_CS_BUSY)) begin
      // Old compute result, if any, becomes host-visible as DONE
      swap = 1'b1; // RULE_09 RULE_10
      start = 1'b1;
      ds_d = (cs_mid == `MAU_CS_DONE) ? `MAU_DS_DONE : `MAU_DS_EMPTY;
      cs_d = `MAU_CS_BUSY; // RULE_09
    end else if ((cs_mid == `MAU_CS_DONE) &&
                 (ds_mid == `MAU_DS_EMPTY)) begin
      swap = 1'b1; // RULE_11
      ds_d = `MAU_DS_DONE;
      cs_d = `MAU_CS_EMPTY;
    end
  end

  // Bank status and role registers
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dbank_q <= 1'b0;
      ds_q <= `MAU_DS_EMPTY; // RULE_19
      cs_q <= `MAU_CS_EMPTY; // RULE_19
    end else begin
      ds_q <= ds_d;
      cs_q <= cs_d;
      if (swap) begin
        dbank_q <= ~dbank_q;
      end
    end
  end

  // Pointer walk; x and y wrap from end to their reload points
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      xptr_q <= `MAU_RST_BYTE;
      yptr_q <= `MAU_RST_BYTE;
      cnt_q <= `MAU_RST_BYTE;
    end else if (start) begin
      // Bank leaving the host side becomes the compute bank
      xptr_q <= xs_q[dbank_q];
      yptr_q <= ys_q[dbank_q];
      cnt_q <= len_q[dbank_q];
    end else if (step) begin
      xptr_q <= (xptr_q == xe_q[cbank]) ? xr_q[cbank] : xptr_q + 8'h01;
      yptr_q <= (yptr_q == ye_q[cbank]) ? yr_q[cbank] : yptr_q + 8'h01;
      cnt_q <= cnt_q - 8'h01;
    end
  end

  // Host writes land in the host bank, steps in the other one
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (b = 0; b < 2; b = b + 1) begin
        xs_q[b] <= `MAU_RST_BYTE;
        xe_q[b] <= `MAU_RST_BYTE;
        xr_q[b] <= `MAU_RST_BYTE;
        ys_q[b] <= `MAU_RST_BYTE;
        ye_q[b] <= `MAU_RST_BYTE;
        yr_q[b] <= `MAU_RST_BYTE;
        len_q[b] <= `MAU_RST_BYTE;
        ctl_q[b] <= `MAU_RST_BYTE;
        acc_q[b] <= `MAU_RST_ACC;
      end
    end else begin
      for (b = 0; b < 2; b = b + 1) begin
        if ((b[0] == cbank) && step) begin
          acc_q[b] <= acc_sum; // RULE_01 RULE_02
        end
        if ((b[0] == dbank_q) && io_wr_i) begin // RULE_16
          case (lo)
            `MAU_XSTART: begin
              xs_q[b] <= io_wdata_i;
            end
            `MAU_XEND: begin
              xe_q[b] <= io_wdata_i;
            end
            `MAU_XRELOAD: begin
              xr_q[b] <= io_wdata_i;
            end
            `MAU_YSTART: begin
              ys_q[b] <= io_wdata_i;
            end
            `MAU_YEND: begin
              ye_q[b] <= io_wdata_i;
            end
            `MAU_YRELOAD: begin
              yr_q[b] <= io_wdata_i;
            end
            `MAU_LENGTH: begin
              len_q[b] <= io_wdata_i;
            end
            `MAU_CTL: begin
              ctl_q[b] <= io_wdata_i;
              if (clr_acc) begin
                acc_q[b] <= `MAU_RST_ACC; // RULE_08
              end
            end
            `MAU_AC0: begin
              acc_q[b][7:0] <= io_wdata_i;
            end
            `MAU_AC1: begin
              acc_q[b][15:8] <= io_wdata_i;
            end
            `MAU_AC2: begin
              acc_q[b][23:16] <= io_wdata_i;
            end
            `MAU_AC3: begin
              acc_q[b][31:24] <= io_wdata_i;
            end
            `MAU_AC4: begin
              acc_q[b][39:32] <= io_wdata_i;
            end
            default: begin
              acc_q[b] <= acc_q[b];
            end
          endcase
        end
      end
    end
  end

  // Read mux over the host bank; unmapped addresses read zero
  assign dacc = acc_q[dbank_q];
  always @* begin
    case (lo)
      `MAU_XSTART: rd_mux = xs_q[dbank_q];
      `MAU_XEND: rd_mux = xe_q[dbank_q];
      `MAU_XRELOAD: rd_mux = xr_q[dbank_q];
      `MAU_YSTART: rd_mux = ys_q[dbank_q];
      `MAU_YEND: rd_mux = ye_q[dbank_q];
      `MAU_YRELOAD: rd_mux = yr_q[dbank_q];
      `MAU_LENGTH: rd_mux = len_q[dbank_q];
      `MAU_CTL: rd_mux = ctl_q[dbank_q];
      `MAU_AC0: rd_mux = dacc[7:0];
      `MAU_AC1: rd_mux = dacc[15:8];
      `MAU_AC2: rd_mux = dacc[23:16];
      `MAU_AC3: rd_mux = dacc[31:24];
      `MAU_AC4: rd_mux = dacc[39:32];
      `MAU_STAT: rd_mux = {4'h0, cs_q, ds_q}; // RULE_17 RULE_18
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data held until the next read strobe
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= `MAU_RST_BYTE;
      mrdata_q <= `MAU_RST_BYTE;
    end else begin
      if (io_rd_i) begin
        rdata_q <= rd_mux;
      end
      if (mem_rd_i) begin
        mrdata_q <= mem_sel_i ? y_byte : x_byte; // RULE_04
      end
    end
  end

  assign io_rdata_o = rdata_q;
  assign mem_rdata_o = mrdata_q;

endmodule // mau_top
`default_nettype wire

// >>> inc/mau_defs.vh
// Register offsets, field positions and codes of the multiply-accumulate unit
`ifndef MAU_DEFS_VH
`define MAU_DEFS_VH

// Register offsets in the low address byte
`define MAU_XSTART 8'h00
`define MAU_XEND 8'h01
`define MAU_XRELOAD 8'h02
`define MAU_YSTART 8'h03
`define MAU_YEND 8'h04
`define MAU_YRELOAD 8'h05
`define MAU_LENGTH 8'h06
`define MAU_CTL 8'h07
`define MAU_AC0 8'h08
`define MAU_AC1 8'h09
`define MAU_AC2 8'h0a
`define MAU_AC3 8'h0b
`define MAU_AC4 8'h0c
`define MAU_STAT 8'h0d

// High address byte marking the final transfer of a block instruction
`define MAU_LAST_XFER 8'h01

// Control register field: signed operands
`define MAU_CTL_SIGNED 0

// Host-facing bank status codes
`define MAU_DS_EMPTY 2'h0
`define MAU_DS_READY 2'h1
`define MAU_DS_DONE 2'h3

// Computing bank status codes
`define MAU_CS_EMPTY 2'h0
`define MAU_CS_BUSY 2'h2
`define MAU_CS_DONE 2'h3

// Reset values
`define MAU_RST_BYTE 8'h00
`define MAU_RST_ACC 40'h00_0000_0000

`endif
